// ### rtl/e3to_tx_overhead.sv
// E3 transmit overhead generation, AIS forcing and framing error insertion.
// Assumes an Avalon-MM master on mclk and a line side that pulls one bit
// per line_tick; upstream marks frame start with in_sof.
//
// Functional notes
// - N bit: one, link, alarm code, zero
// - A bit: auto, alarm code, zero, one
// - Shared alarm code stream, one bit/frame
// - Generation enabled replaces overhead positions
// - Generation disabled passes overhead unchanged
// - Overhead insertion still overwrites overhead
// - AIS control forces all-ones output
// - Error type: bit/word, one/four frames
// - Error bursts start only while enabled; a started burst runs to its end
// - Software bit rising edge injects one
// - Many toggles yield one error
// - Manual mode uses external trigger input
// - Auto A bit from maskable receive alarms
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "e3to_params.svh"
module e3to_tx_overhead (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        in_data,
  input  wire logic        in_sof,
  input  wire logic        in_ohi_valid,
  input  wire logic        in_ohi_bit,
  input  wire logic        in_valid,
  output wire logic        in_ready,
  input  wire logic        line_tick,
  output logic             line_bit,
  output logic             line_valid,
  input  wire logic        hdlc_bit,
  output logic             hdlc_next,
  input  wire logic        feac_bit,
  output logic             feac_next,
  input  wire logic        ext_err_trigger_in,
  input  wire logic        rx_los,
  input  wire logic        rx_oof,
  input  wire logic        rx_ais,
  input  wire logic        rx_lof
);
  localparam int WW = $bits(e3to_pkg::e3to_word_s);
  localparam logic [9:0] FAS = `E3TO_FAS_WORD;

  logic [15:0]          tx_control;
  logic [15:0]          tx_err;
  logic [15:0]          rai_ctl;
  logic [4:0]           sync_q;
  logic                 ext_s, los_s, oof_s, ais_s, lof_s;
  e3to_pkg::e3to_sel_t  n_bit_source_sel, a_bit_source_sel, frame_err_type_sel;
  logic                 frame_gen_disable, force_all_ones_out;
  logic                 frame_err_inject_en, sw_single_err_trigger, manual_err_source_sel;
  logic                 rai_on_frame_loss_en, rai_on_sig_loss_dis, rai_on_oof_dis;
  logic                 rai_on_ais_dis;
  logic                 rai_now, trig_src, trig_prev, trig_edge, err_pending;
  logic [2:0]           frames_left, eff_left, load_left;
  logic                 word_mode, eff_word;
  logic [10:0]          pos, cur_pos;
  e3to_pkg::e3to_word_s head;
  logic                 pop, opp, oh_pos, gen_bit, mid_bit, inj, next_line_bit;
  logic [7:0]           idx;
  logic [15:0]          rd_mux;

  e3to_stream_if #(.W(WW)) bus_if ();

  e3to_fifo #(.WIDTH(WW), .DEPTH(`E3TO_FIFO_DEPTH)) u_fifo (
    .mclk (mclk),
    .rst  (rst),
    .s    (bus_if.fifo)
  );

  assign bus_if.push_data  = {in_sof, in_ohi_valid, in_ohi_bit, in_data};
  assign bus_if.push_valid = in_valid;
  assign bus_if.pop_ready  = line_tick;
  assign in_ready          = bus_if.push_ready;
  assign head              = bus_if.pop_data;

  e3to_sync #(.W(5)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({rx_lof, rx_ais, rx_oof, rx_los, ext_err_trigger_in}),
    .dout (sync_q)
  );
  assign {lof_s, ais_s, oof_s, los_s, ext_s} = sync_q;

  assign n_bit_source_sel      = tx_control[`E3TO_N_SEL_LSB +: 2];
  assign a_bit_source_sel      = tx_control[`E3TO_A_SEL_LSB +: 2];
  assign frame_gen_disable     = tx_control[`E3TO_FGD_BIT];
  assign force_all_ones_out    = tx_control[`E3TO_AIS_BIT];
  assign frame_err_type_sel    = tx_err[`E3TO_ERR_TYPE_LSB +: 2];
  assign frame_err_inject_en   = tx_err[`E3TO_ERR_EN_BIT];
  assign sw_single_err_trigger = tx_err[`E3TO_SW_TRIG_BIT];
  assign manual_err_source_sel = tx_err[`E3TO_MANUAL_BIT];
  assign rai_on_frame_loss_en  = rai_ctl[`E3TO_RAI_LOF_EN_BIT];
  assign rai_on_sig_loss_dis   = rai_ctl[`E3TO_RAI_LOS_DIS_BIT];
  assign rai_on_oof_dis        = rai_ctl[`E3TO_RAI_OOF_DIS_BIT];
  assign rai_on_ais_dis        = rai_ctl[`E3TO_RAI_AIS_DIS_BIT];

  // Register bus: one wait cycle, then the access completes
  assign idx = avs_address[9:2];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~lanes) | (wd[15:0] & lanes);
  endfunction

  always_comb begin
    rd_mux = 16'h0000;
    if (idx == `E3TO_IDX_TX_CONTROL) begin
      rd_mux = tx_control;
    end else if (idx == `E3TO_IDX_TX_ERR) begin
      rd_mux = tx_err;
    end else if (idx == `E3TO_IDX_RAI_CTL) begin
      rd_mux = rai_ctl;
    end else if (idx == `E3TO_IDX_STATUS) begin
      rd_mux = {6'h00, trig_src, lof_s, ais_s, oof_s, los_s, rai_now, frames_left,
                err_pending};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_control <= `E3TO_RST_TX_CONTROL;
      tx_err     <= `E3TO_RST_TX_ERR;
      rai_ctl    <= `E3TO_RST_RAI_CTL;
    end else if (avs_write && !avs_waitrequest) begin
      if (idx == `E3TO_IDX_TX_CONTROL) begin
        tx_control <= merge(tx_control, avs_writedata, avs_byteenable,
                            `E3TO_WMASK_TX_CONTROL);
      end else if (idx == `E3TO_IDX_TX_ERR) begin
        tx_err <= merge(tx_err, avs_writedata, avs_byteenable, `E3TO_WMASK_TX_ERR);
      end else if (idx == `E3TO_IDX_RAI_CTL) begin
        rai_ctl <= merge(rai_ctl, avs_writedata, avs_byteenable, `E3TO_WMASK_RAI_CTL);
      end
    end
  end

  // Trigger source: mode switch while a source is high can look like an edge
  assign trig_src  = manual_err_source_sel ? ext_s : sw_single_err_trigger;
  assign trig_edge = trig_src && !trig_prev;

  assign rai_now = (los_s && !rai_on_sig_loss_dis) || (oof_s && !rai_on_oof_dis) ||
                   (ais_s && !rai_on_ais_dis) || (lof_s && rai_on_frame_loss_en);

  // Frame position of the bit at the FIFO head
  assign pop     = bus_if.pop_valid && line_tick;
  assign cur_pos = head.sof ? 11'h000 : ((pos == `E3TO_POS_IDLE) ? pos : pos + 11'h001);
  assign oh_pos  = (cur_pos <= `E3TO_N_POS);

  // Opportunity is the first bit of a frame
  assign opp       = pop && head.sof && err_pending && frame_err_inject_en;
  assign load_left = frame_err_type_sel[1] ? `E3TO_ERR_FRAMES_FOUR
                                           : `E3TO_ERR_FRAMES_ONE;
  assign eff_left  = opp ? load_left : frames_left;
  assign eff_word  = opp ? frame_err_type_sel[0] : word_mode;

  always_comb begin
    gen_bit = 1'b0;
    if (cur_pos < `E3TO_FAS_LEN) begin
      gen_bit = FAS[4'(10'(`E3TO_FAS_LEN) - 10'(cur_pos) - 10'h001)];
    end else if (cur_pos == `E3TO_A_POS) begin
      case (a_bit_source_sel)
        2'h0:    gen_bit = rai_now;
        2'h1:    gen_bit = feac_bit;
        2'h2:    gen_bit = 1'b0;
        default: gen_bit = 1'b1;
      endcase
    end else begin
      case (n_bit_source_sel)
        2'h0:    gen_bit = 1'b1;
        2'h1:    gen_bit = hdlc_bit;
        2'h2:    gen_bit = feac_bit;
        default: gen_bit = 1'b0;
      endcase
    end
  end

  always_comb begin
    mid_bit = (oh_pos && !frame_gen_disable) ? gen_bit : head.data;
    if (oh_pos && head.ohi_valid) mid_bit = head.ohi_bit;
    inj = (cur_pos < `E3TO_FAS_LEN) && (eff_left != 3'h0) &&
          (eff_word || cur_pos == 11'h000);
    next_line_bit = force_all_ones_out ? 1'b1 : (mid_bit ^ inj);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      line_bit   <= 1'b1;
      line_valid <= 1'b0;
      pos        <= `E3TO_POS_IDLE;
    end else begin
      line_valid <= pop;
      if (pop) begin
        line_bit <= next_line_bit;
        pos      <= cur_pos;
      end
    end
  end

  // Set wins over the clear taken at the opportunity
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_prev   <= 1'b0;
      err_pending <= 1'b0;
    end else begin
      trig_prev <= trig_src;
      if (trig_edge && frame_err_inject_en) begin
        err_pending <= 1'b1;
      end else if (opp) begin
        err_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      frames_left <= 3'h0;
      word_mode   <= 1'b0;
    end else if (pop) begin
      word_mode <= eff_word;
      if (cur_pos == `E3TO_FAS_LEN - 11'h001 && eff_left != 3'h0) begin
        frames_left <= eff_left - 3'h1;
      end else begin
        frames_left <= eff_left;
      end
    end
  end

  // One alarm code bit per frame even when both overhead bits use it
  always_ff @(posedge mclk) begin
    if (rst) begin
      feac_next <= 1'b0;
      hdlc_next <= 1'b0;
    end else begin
      feac_next <= pop && cur_pos == `E3TO_N_POS &&
                   (n_bit_source_sel == 2'h2 || a_bit_source_sel == 2'h1);
      hdlc_next <= pop && cur_pos == `E3TO_N_POS && n_bit_source_sel == 2'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence plain_oh_s;
    pop && !force_all_ones_out && !head.ohi_valid && eff_left == 3'h0;
  endsequence

  n_bit_one_a: assert property (plain_oh_s and (cur_pos == `E3TO_N_POS && !frame_gen_disable
      && n_bit_source_sel == 2'h0) |=> line_bit && line_valid)
    else $error("N bit not one");
  a_bit_zero_a: assert property (plain_oh_s and (cur_pos == `E3TO_A_POS
      && !frame_gen_disable && a_bit_source_sel == 2'h2) |=> !line_bit)
    else $error("A bit not zero");
  fas_gen_a: assert property (plain_oh_s and (cur_pos == 11'h004
      && !frame_gen_disable) |=> line_bit == FAS[5])
    else $error("FAS bit wrong");
  oh_pass_a: assert property (plain_oh_s and (oh_pos && frame_gen_disable)
      |=> line_bit == $past(head.data))
    else $error("Overhead not passed");
  oh_insert_a: assert property ((pop && oh_pos && head.ohi_valid && !force_all_ones_out
      && cur_pos >= `E3TO_FAS_LEN) |=> line_bit == $past(head.ohi_bit))
    else $error("Overhead insertion lost");
  ais_force_a: assert property ((pop && force_all_ones_out) |=> line_bit)
    else $error("AIS not all ones");
  burst_load_a: assert property (opp |=> frames_left == $past(load_left))
    else $error("Burst length wrong");
  no_inject_a: assert property ((!frame_err_inject_en && frames_left == 3'h0
      && !err_pending) |=> (frames_left == 3'h0 && !err_pending))
    else $error("Error while disabled");

  sequence sw_rise_s;
    !manual_err_source_sel && frame_err_inject_en && $rose(sw_single_err_trigger);
  endsequence
  sw_trigger_a: assert property (sw_rise_s ##1 !opp |=> err_pending)
    else $error("Software trigger lost");
  ext_trigger_a: assert property ((manual_err_source_sel && frame_err_inject_en
      && ext_s && !trig_prev) |=> err_pending)
    else $error("External trigger lost");
endmodule // e3to_tx_overhead
`default_nettype wire

// ### rtl/e3to_params.svh
// Constants of the E3 transmit overhead and error insertion block.
// Assumes inclusion by bare name from every file that needs it.
`ifndef E3TO_PARAMS_SVH
`define E3TO_PARAMS_SVH

// Register indices; byte address is four times the index
`define E3TO_IDX_TX_CONTROL  8'h18
`define E3TO_IDX_TX_ERR      8'h1A
`define E3TO_IDX_RAI_CTL     8'h20
`define E3TO_IDX_STATUS      8'h24

`define E3TO_RST_TX_CONTROL  16'h0000
`define E3TO_RST_TX_ERR      16'h0000
`define E3TO_RST_RAI_CTL     16'h0000
`define E3TO_WMASK_TX_CONTROL 16'h030F
`define E3TO_WMASK_TX_ERR    16'h001F
`define E3TO_WMASK_RAI_CTL   16'h00F0

// Control register fields
`define E3TO_N_SEL_LSB       8
`define E3TO_A_SEL_LSB       2
`define E3TO_FGD_BIT         1
`define E3TO_AIS_BIT         0
// Error insertion register fields
`define E3TO_ERR_TYPE_LSB    3
`define E3TO_ERR_EN_BIT      2
`define E3TO_SW_TRIG_BIT     1
`define E3TO_MANUAL_BIT      0
// Alarm steering fields
`define E3TO_RAI_LOF_EN_BIT  7
`define E3TO_RAI_LOS_DIS_BIT 6
`define E3TO_RAI_OOF_DIS_BIT 5
`define E3TO_RAI_AIS_DIS_BIT 4

// Frame layout
`define E3TO_FAS_WORD        10'h3D0
`define E3TO_FAS_LEN         11'h00A
`define E3TO_A_POS           11'h00A
`define E3TO_N_POS           11'h00B
`define E3TO_POS_IDLE        11'h7FF
`define E3TO_ERR_FRAMES_ONE  3'h1
`define E3TO_ERR_FRAMES_FOUR 3'h4
`define E3TO_FIFO_DEPTH      8

`endif

// ### rtl/e3to_pkg.sv
// Types shared by the E3 transmit overhead block and its FIFO.
// Assumes nothing beyond a SystemVerilog compiler.
package e3to_pkg;
  typedef logic [1:0] e3to_sel_t;

  typedef struct packed {
    logic sof;
    logic ohi_valid;
    logic ohi_bit;
    logic data;
  } e3to_word_s;
endpackage

// ### rtl/e3to_stream_if.sv
// Push and pop sides of the transmit bit FIFO.
// Assumes one clock shared by both sides.
`timescale 1ns/100ps
`default_nettype none
interface e3to_stream_if #(parameter int W = 4);
  logic [W-1:0] push_data;
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] pop_data;
  logic         pop_valid;
  logic         pop_ready;

  modport fifo (input push_data, input push_valid, output push_ready,
                output pop_data, output pop_valid, input pop_ready);
  modport user (output push_data, output push_valid, input push_ready,
                input pop_data, input pop_valid, output pop_ready);
endinterface
`default_nettype wire

// ### rtl/e3to_fifo.sv
// Show-ahead FIFO in the transmit bit path.
// Assumes DEPTH is a power of two and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module e3to_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input wire logic     mclk,
  input wire logic     rst,
  e3to_stream_if.fifo  s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push        = s.push_valid && s.push_ready;
  assign pop         = s.pop_valid && s.pop_ready;
  assign s.pop_valid = (count != '0);
  assign s.pop_data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Ready is registered so the source sees a clean level
  always_ff @(posedge mclk) begin
    if (rst) begin
      count        <= '0;
      s.push_ready <= 1'b1;
    end else begin
      count        <= next_count;
      s.push_ready <= (next_count != FULL);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) mem[wr_ptr] <= s.push_data;
  end
endmodule // e3to_fifo
`default_nettype wire

// ### rtl/e3to_sync.sv
// Three-stage synchroniser for levels arriving from outside mclk.
// Output moves only when the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module e3to_sync #(
  parameter int W = 5
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output wire logic [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic q;
      always_ff @(posedge mclk) begin
        if (rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          q  <= 1'b0;
        end else begin
          s1 <= din[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) q <= s3;
        end
      end
      assign dout[i] = q;
    end
  endgenerate
endmodule // e3to_sync
`default_nettype wire

// ### test/e3to_line_sink.sv
// Line-side model of the far-end E3 terminal: pulls bits and records them.
// Assumes line_bit stands settled whenever line_valid is high at an edge.
`timescale 1ns/100ps
`default_nettype none
module e3to_line_sink (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic stall,
  input  wire logic line_bit,
  input  wire logic line_valid,
  output logic      line_tick
);
  logic got[$];
  int   seed = 32'h6EDB859C;

  initial line_tick = 1'b0;

  // Random gaps so the FIFO sees both bursts and idle line slots
  always @(posedge mclk) begin
    line_tick <= !rst && !stall && ($random(seed) % 4 != 0);
    if (!rst && line_valid === 1'b1) begin
      got.push_back(line_bit);
    end
  end
endmodule // e3to_line_sink
`default_nettype wire

// ### test/e3_tx_overhead_error_insert_tb_top.sv
// Self-checking bench for the E3 transmit overhead and error insertion block.
// Assumes the line-side model e3to_line_sink and registers on Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "e3to_params.svh"
module e3_tx_overhead_error_insert_tb_top;
  localparam logic [9:0] FAS = `E3TO_FAS_WORD;
  logic        mclk, rst, stall, line_tick, line_bit, line_valid, in_ready, avs_waitrequest;
  logic [9:0]  avs_address;
  logic        avs_read, avs_write, in_data, in_sof, in_ohi_valid, in_ohi_bit, in_valid;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        hdlc_bit, feac_bit, ext_err_trigger_in, rx_los, rx_oof, rx_ais, rx_lof;
  logic        hdlc_next, feac_next;
  int          n_hdlc, n_feac, b_hdlc, b_feac;
  int          n_mismatch, compares, left;
  int          seed = 32'h6EDB859C;
  logic [1:0]  n_sel, a_sel;
  logic [3:0]  st;
  logic        fgd, ais, pend, four, word;
  logic        expq[$];

  e3to_tx_overhead u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_data(in_data), .in_sof(in_sof),
    .in_ohi_valid(in_ohi_valid), .in_ohi_bit(in_ohi_bit), .in_valid(in_valid),
    .in_ready(in_ready), .line_tick(line_tick), .line_bit(line_bit),
    .line_valid(line_valid), .hdlc_bit(hdlc_bit), .hdlc_next(hdlc_next), .feac_bit(feac_bit),
    .feac_next(feac_next), .ext_err_trigger_in(ext_err_trigger_in), .rx_los(rx_los),
    .rx_oof(rx_oof), .rx_ais(rx_ais), .rx_lof(rx_lof));
  e3to_line_sink u_line (.mclk(mclk), .rst(rst), .stall(stall), .line_bit(line_bit),
    .line_valid(line_valid), .line_tick(line_tick));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Counts side-channel pull pulses; checked as deltas per scenario
  always @(posedge mclk) begin
    if (hdlc_next === 1'b1) n_hdlc++;
    if (feac_next === 1'b1) n_feac++;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int w;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    for (w = 0; w < 50; w++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (w == 50) begin n_mismatch++; print_verdict(); end
  endtask

  task automatic wreg(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic set_ctl();
    wreg(10'h060, {22'h0, n_sel, 4'h0, a_sel, fgd, ais});
  endtask

  task automatic werr(input logic [1:0] t, input logic en, sw, man);
    wreg(10'h068, {27'h0, t, en, sw, man});
  endtask

  // Valid is held across back-to-back pushes; caller drops it
  task automatic push(input logic d, s, ov, ob);
    int w;
    in_valid <= 1'b1;
    in_data <= d;
    in_sof <= s;
    in_ohi_valid <= ov;
    in_ohi_bit <= ob;
    for (w = 0; w < 200; w++) begin
      @(posedge mclk);
      if (in_ready === 1'b1) break;
    end
    if (w == 200) begin n_mismatch++; print_verdict(); end
  endtask

  // Reference model: 16-bit frames, overhead at 0..11, payload after
  task automatic send_frames(input int nf);
    logic d, ov, ob, e, ferr, a_v, n_v, auto_a;
    auto_a = (rx_los & !st[2]) | (rx_oof & !st[1]) | (rx_ais & !st[0]) | (rx_lof & st[3]);
    a_v = (a_sel == 2'h0) ? auto_a : (a_sel == 2'h1) ? feac_bit : a_sel[0];
    n_v = (n_sel == 2'h0) ? 1'b1 : (n_sel == 2'h1) ? hdlc_bit : (n_sel == 2'h2) ? feac_bit : 1'b0;
    for (int f = 0; f < nf; f++) begin
      ferr = 1'b0;
      if (pend) begin left = four ? 4 : 1; pend = 1'b0; end
      if (left > 0) begin ferr = 1'b1; left--; end
      for (int p = 0; p < 16; p++) begin
        d = 1'($random(seed));
        ov = ($random(seed) % 4 == 0);
        ob = 1'($random(seed));
        if (ov && p < 12) e = ob;
        else if (!fgd && p < 10) e = FAS[9-p];
        else if (!fgd && p == 10) e = a_v;
        else if (!fgd && p == 11) e = n_v;
        else e = d;
        if (ferr && p < 10 && (word || p == 0)) e = !e;
        if (ais) e = 1'b1;
        expq.push_back(e);
        push(d, p == 0, ov, ob);
      end
    end
    in_valid <= 1'b0;
  endtask

  task automatic drain();
    int w;
    for (w = 0; w < 3000 && u_line.got.size() < expq.size(); w++) @(posedge mclk);
    if (w == 3000) begin n_mismatch++; print_verdict(); end
    repeat (4) @(posedge mclk);
    chk("bit count", 32'(u_line.got.size()), 32'(expq.size()));
    foreach (expq[i]) chk("line_bit", 32'(u_line.got[i]), 32'(expq[i]));
    u_line.got.delete();
    expq.delete();
  endtask

  initial begin
    logic [31:0] r;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    {in_data, in_sof, in_ohi_valid, in_ohi_bit, in_valid, stall} = '0;
    {hdlc_bit, feac_bit, ext_err_trigger_in, rx_los, rx_oof, rx_ais, rx_lof} = '0;
    {n_sel, a_sel, fgd, ais, pend, four, word, st} = '0;
    left = 0;
    rst = 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("line_bit idle", 32'(line_bit), 32'h1);
    rreg_chk(10'h060, 32'h0000, "tx_control");
    rreg_chk(10'h068, 32'h0000, "tx_error_insert");
    wreg(10'h060, 32'hFFFF);
    rreg_chk(10'h060, 32'h030F, "tx_control mask");
    wreg(10'h068, 32'h0019);
    rreg_chk(10'h068, 32'h0019, "tx_error_insert mask");
    wreg(10'h070, 32'hFFFF);
    rreg_chk(10'h070, 32'h0000, "unmapped");
    wreg(10'h060, 32'h0);
    wreg(10'h068, 32'h0);
    for (int i = 0; i < 16; i++) begin
      n_sel = i[3:2];
      a_sel = i[1:0];
      st = 4'($random(seed));
      hdlc_bit <= 1'($random(seed));
      feac_bit <= 1'($random(seed));
      {rx_lof, rx_los, rx_oof, rx_ais} <= 4'($random(seed));
      wreg(10'h080, {24'h0, st, 4'h0});
      set_ctl();
      repeat (8) @(posedge mclk);
      b_hdlc = n_hdlc;
      b_feac = n_feac;
      send_frames(2);
      drain();
      chk("hdlc pulses", 32'(n_hdlc - b_hdlc), 32'(2 * (n_sel == 2'h1)));
      chk("feac pulses", 32'(n_feac - b_feac), 32'(2 * (n_sel == 2'h2 || a_sel == 2'h1)));
    end
    for (int t = 0; t < 4; t++) begin
      four = t[1];
      word = t[0];
      werr(t[1:0], 1'b1, 1'b0, 1'b0);
      for (int k = 0; k < 3; k++) begin
        werr(t[1:0], 1'b1, 1'b1, 1'b0);
        werr(t[1:0], 1'b1, 1'b0, 1'b0);
      end
      werr(t[1:0], 1'b1, 1'b1, 1'b0);
      rreg_chk(10'h090 , 32'h1, "pending", 32'h1);
      pend = 1'b1;
      send_frames(5);
      drain();
    end
    werr(2'h3, 1'b1, 1'b1, 1'b0);
    send_frames(2);
    drain();
    werr(2'h1, 1'b0, 1'b0, 1'b0);
    werr(2'h1, 1'b0, 1'b1, 1'b0);
    rreg_chk(10'h090, 32'h0, "pending off", 32'h1);
    send_frames(2);
    drain();
    werr(2'h1, 1'b1, 1'b0, 1'b0);
    werr(2'h1, 1'b1, 1'b0, 1'b1);
    ext_err_trigger_in <= 1'b1;
    repeat (8) @(posedge mclk);
    ext_err_trigger_in <= 1'b0;
    repeat (8) @(posedge mclk);
    {pend, four, word} = 3'b101;
    send_frames(2);
    drain();
    fgd = 1'b1;
    set_ctl();
    send_frames(2);
    drain();
    stall <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int k = 0; k < 8; k++) begin
      r[0] = 1'($random(seed));
      expq.push_back(r[0]);
      push(r[0], 1'b0, 1'b0, 1'b0);
    end
    in_valid <= 1'b0;
    @(posedge mclk);
    chk("in_ready full", 32'(in_ready), 32'h0);
    stall <= 1'b0;
    drain();
    ais = 1'b1;
    set_ctl();
    send_frames(2);
    drain();
    print_verdict();
  end

  task automatic rreg_chk(input logic [9:0] a, input logic [31:0] exp, input string what,
                          input logic [31:0] mask = 32'hFFFF_FFFF);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(what, r & mask, exp);
  endtask
endmodule // e3_tx_overhead_error_insert_tb_top
`default_nettype wire
